/* sro_pkg.sv */
`default_nettype none
package sro_pkg;
  // result width and conversion timing
  localparam int RESULT_BITS    = 14;
  localparam int CLK_PERIOD_PS  = 5000;
  localparam int CONV_TIME_NS   = 2000;
  localparam int CONV_CYCLES    = (CONV_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // serial frame
  localparam logic START_BIT    = 1'b0;
  localparam int EDGE_CNT_BITS  = 4;
  localparam int PIN_COUNT      = 3;
  localparam int PIN_CNV        = 0;
  localparam int PIN_SDI        = 1;
  localparam int PIN_SCK        = 2;
  localparam logic RESET_MODE_CS = 1'b1;
  // conversion sequencer, gray from ST_ACQ to ST_CONV to ST_FINISH; the return to ST_ACQ flips both bits
  typedef enum logic [1:0] {
    ST_ACQ    = 2'b00,
    ST_CONV   = 2'b01,
    ST_FINISH = 2'b11
  } sro_state_type;
endpackage : sro_pkg
`default_nettype wire

/* sro_sar_adc_readout.sv */
// Summary of operation
// RULE1: conversion-start rise samples select input; high picks chip-select, low picks chain mode.
// RULE2: select tied to conversion-start always yields chain mode, via select hold.
// RULE3: an optional start bit ahead of data acts as busy indicator.
// RULE4: without busy indicator the host waits maximum conversion time before reading.
// RULE5: chip-select mode enables busy if conversion-start or select is low at end.
// RULE6: chain mode enables busy only if serial clock high at conversion-start rise.
// RULE7: conversion-start rise begins conversion, picks interface mode from select, floats serial output.
// RULE8: a started conversion completes whatever conversion-start does afterwards.
// RULE9: host returns conversion-start high before minimum, holds it until maximum time.
// RULE10: after each conversion the device returns to acquisition and powers down.
// RULE11: without busy, conversion-start fall drives the result MSB onto serial output.
// RULE12: each later result bit shifts out on successive serial clock falling edges.
// RULE13: each output bit stays valid across both serial clock edges.
// RULE14: serial output floats at the fourteenth falling edge or conversion-start rise; code: fifteenth with busy bit, no edge count in chain mode.
// RULE15: chip-select mode works as 3-wire link or 4-wire with select gating readback.
// RULE16: in chain mode the select input feeds the output shift register.
// RULE17: result is straight binary, clamped to zero and full scale.
// RULE18: conversion is timed by the internal clock, not the serial clock.
// RULE19: the result holds until the next conversion-start rise begins a conversion; the code keeps it until that conversion ends.
`timescale 1ns/1ps
`default_nettype none
module sro_sar_adc_readout #(
  parameter int RESULT_BITS = sro_pkg::RESULT_BITS,
  parameter int CONV_CYCLES = sro_pkg::CONV_CYCLES
) (
  // system
  input  wire logic                          clk,
  input  wire logic                          srst,
  // host pins
  input  wire logic                          conversionStartInput,
  input  wire logic                          selectChainInput,
  input  wire logic                          serialClock,
  output logic                               serialResultOutput,
  output logic                               serialResultOutputOeN,
  // analog core
  input  wire logic signed [RESULT_BITS+1:0] sampleLevel,
  output logic                               acquiring,
  output logic             [RESULT_BITS-1:0] resultCode
);
  localparam int EW = sro_pkg::EDGE_CNT_BITS;
  localparam int SW = RESULT_BITS + 1;
  localparam int FW = $clog2(RESULT_BITS + 2);
  localparam int CW = $clog2(CONV_CYCLES + 1);
  localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYCLES - 1);
  generate
    if (RESULT_BITS < 2 || RESULT_BITS > 16 || CONV_CYCLES < 9) begin : g_bad_param
      $error("sro_sar_adc_readout: unsupported parameter value");
    end
  endgenerate
  function automatic logic [EW-1:0] gray2bin(input logic [EW-1:0] g);
    logic [EW-1:0] b;
    b[EW-1] = g[EW-1];
    for (int i = EW - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : gray2bin

  function automatic logic [RESULT_BITS-1:0] clampCode(input logic signed [RESULT_BITS+1:0] v);
    if (v < 0) begin
      return '0;
    end else if (v > $signed({2'b00, {RESULT_BITS{1'b1}}})) begin
      return '1;
    end else begin
      return v[RESULT_BITS-1:0];
    end
  endfunction : clampCode

  // pin filters: three flops, level moves when stages two and three agree
  logic [sro_pkg::PIN_COUNT-1:0] pinRaw;
  logic [sro_pkg::PIN_COUNT-1:0] pinS1;
  logic [sro_pkg::PIN_COUNT-1:0] pinS2;
  logic [sro_pkg::PIN_COUNT-1:0] pinS3;
  logic [sro_pkg::PIN_COUNT-1:0] pinLevel;
  logic [sro_pkg::PIN_COUNT-1:0] pinPrev;
  assign pinRaw = {serialClock, selectChainInput, conversionStartInput};
  always_ff @(posedge clk) begin
    if (srst) begin
      pinS1    <= '0;
      pinS2    <= '0;
      pinS3    <= '0;
      pinLevel <= '0;
      pinPrev  <= '0;
    end else begin
      pinS1    <= pinRaw;
      pinS2    <= pinS1;
      pinS3    <= pinS2;
      pinLevel <= (pinS2 & pinS3) | (pinLevel & (pinS2 ^ pinS3));
      pinPrev  <= pinLevel;
    end
  end

  logic cnvLevel;
  logic sdiLevel;
  logic sdiPrev;
  logic sckPrev;
  logic cnvRise;
  logic selectLevel;
  logic selectPrev;
  assign cnvLevel    = pinLevel[sro_pkg::PIN_CNV];
  assign sdiLevel    = pinLevel[sro_pkg::PIN_SDI];
  assign sdiPrev     = pinPrev[sro_pkg::PIN_SDI];
  assign sckPrev     = pinPrev[sro_pkg::PIN_SCK];
  assign cnvRise     = cnvLevel & ~pinPrev[sro_pkg::PIN_CNV];
  // 3-wire selects by conversion-start low, 4-wire by select low
  assign selectLevel = ~cnvLevel | ~sdiLevel; // RULE15
  assign selectPrev  = ~pinPrev[sro_pkg::PIN_CNV] | ~pinPrev[sro_pkg::PIN_SDI];

  // link domain: counts serial clock falling edges, captures select input
  logic [EW-1:0] linkCount = '0;
  logic [EW-1:0] linkGray  = '0;
  logic          linkSdi   = 1'b0;
  logic [EW-1:0] linkNext;
  assign linkNext = linkCount + 1'b1;
  always_ff @(negedge serialClock) begin
    linkCount <= linkNext;
    linkGray  <= linkNext ^ (linkNext >> 1);
    linkSdi   <= selectChainInput; // RULE16
  end

  // gray edge count into the system domain
  logic [EW-1:0] grayS1;
  logic [EW-1:0] grayS2;
  logic [EW-1:0] seenBin;
  logic [EW-1:0] syncBin;
  logic          edgeSeen;
  assign syncBin  = gray2bin(grayS2);
  assign edgeSeen = syncBin != seenBin;
  always_ff @(posedge clk) begin
    grayS1 <= linkGray;
    grayS2 <= grayS1;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      seenBin <= syncBin;
    end else if (edgeSeen) begin
      seenBin <= seenBin + 1'b1;
    end
  end

  // conversion sequencer on the internal clock
  sro_pkg::sro_state_type state;
  logic [CW-1:0]                 convCount;
  logic                          convStart;
  logic                          convLast;
  logic                          csMode;
  logic                          chainBusy;
  logic signed [RESULT_BITS+1:0] sampleHeld;
  assign convStart = (state == sro_pkg::ST_ACQ) && cnvRise;
  assign convLast  = (state == sro_pkg::ST_CONV) && (convCount == CONV_LAST);
  always_ff @(posedge clk) begin
    if (srst) begin
      state     <= sro_pkg::ST_ACQ;
      convCount <= '0;
    end else begin
      case (state)
        sro_pkg::ST_ACQ: begin
          if (cnvRise) begin
            state     <= sro_pkg::ST_CONV; // RULE7
            convCount <= '0;
          end
        end
        sro_pkg::ST_CONV: begin
          if (convCount == CONV_LAST) begin
            state <= sro_pkg::ST_FINISH;
          end else begin
            convCount <= convCount + 1'b1; // RULE8 RULE18
          end
        end
        sro_pkg::ST_FINISH: begin
          state <= sro_pkg::ST_ACQ; // RULE10
        end
        default: begin
          state <= sro_pkg::ST_ACQ;
        end
      endcase
    end
  end

  // mode, busy option and sample captured at conversion start
  always_ff @(posedge clk) begin
    if (srst) begin
      csMode     <= sro_pkg::RESET_MODE_CS;
      chainBusy  <= 1'b0;
      sampleHeld <= '0;
    end else if (convStart) begin
      csMode     <= sdiPrev; // RULE1 RULE2
      chainBusy  <= sckPrev; // RULE6
      sampleHeld <= sampleLevel;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      resultCode <= '0;
    end else if (convLast) begin
      resultCode <= clampCode(sampleHeld); // RULE17 RULE19
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      acquiring <= 1'b1;
    end else if (convStart) begin
      acquiring <= 1'b0;
    end else if (state == sro_pkg::ST_FINISH) begin
      acquiring <= 1'b1; // RULE10
    end
  end

  // readout shift register and output drive
  logic [SW-1:0] shiftReg;
  logic [FW-1:0] bitsLeft;
  logic          driving;
  logic          armed;
  logic          chainRun;
  logic          readStart;
  logic [SW-1:0] next_shift;
  logic [FW-1:0] next_left;
  logic          next_drive;
  logic          next_armed;
  logic          next_chain;
  assign readStart = armed && selectLevel && !selectPrev && !convStart;
  always_comb begin
    next_shift = shiftReg;
    next_left  = bitsLeft;
    next_drive = driving;
    next_armed = armed;
    next_chain = chainRun;
    if (convStart) begin
      next_drive = 1'b0; // RULE7
      next_left  = '0;
      next_armed = 1'b0;
      next_chain = 1'b0;
    end else if (state == sro_pkg::ST_FINISH) begin
      if (!csMode) begin
        next_chain = 1'b1;
        next_drive = 1'b1;
        next_shift = chainBusy ? {sro_pkg::START_BIT, resultCode} : {resultCode, 1'b0}; // RULE3 RULE6
      end else if (!cnvLevel || !sdiLevel) begin
        next_drive = 1'b1; // RULE5
        next_shift = {sro_pkg::START_BIT, resultCode}; // RULE3
        next_left  = FW'(RESULT_BITS + 1);
      end else begin
        next_armed = 1'b1;
      end
    end else begin
      if (readStart) begin
        next_armed = 1'b0;
        next_drive = 1'b1; // RULE11
        next_shift = {resultCode, 1'b0};
        next_left  = FW'(RESULT_BITS);
      end else if (edgeSeen && driving) begin
        next_shift = {shiftReg[SW-2:0], linkSdi}; // RULE12 RULE13 RULE16
        if (chainRun && !chainBusy) begin
          next_shift = {shiftReg[SW-2:1], linkSdi, 1'b0}; // RULE16
        end
        if (!chainRun) begin
          next_left = bitsLeft - 1'b1;
          if (bitsLeft == FW'(1)) begin
            next_drive = 1'b0; // RULE14
          end
        end
      end
      if (!chainRun && driving && !selectLevel && selectPrev) begin
        next_drive = 1'b0; // RULE14 RULE15
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      shiftReg              <= '0;
      bitsLeft              <= '0;
      driving               <= 1'b0;
      armed                 <= 1'b0;
      chainRun              <= 1'b0;
      serialResultOutput    <= 1'b0;
      serialResultOutputOeN <= 1'b1;
    end else begin
      shiftReg              <= next_shift;
      bitsLeft              <= next_left;
      driving               <= next_drive;
      armed                 <= next_armed;
      chainRun              <= next_chain;
      serialResultOutput    <= next_shift[SW-1];
      serialResultOutputOeN <= !next_drive;
    end
  end

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  sequence s_start;
    (state == sro_pkg::ST_ACQ) && cnvRise;
  endsequence
  sequence s_convEnd;
    convLast;
  endsequence
  property p_mode_select;
    s_start |=> (csMode == $past(sdiPrev));
  endproperty
  a_mode_select: assert property (p_mode_select) else $error("mode not taken from select input"); // RULE1
  property p_tied_chain;
    (s_start and (sdiLevel && !sdiPrev)) |=> !csMode;
  endproperty
  a_tied_chain: assert property (p_tied_chain) else $error("tied select did not give chain mode"); // RULE2
  property p_hiz_on_start;
    s_start |=> (serialResultOutputOeN && state == sro_pkg::ST_CONV && !acquiring);
  endproperty
  a_hiz_on_start: assert property (p_hiz_on_start) else $error("start did not float output"); // RULE7
  property p_conv_runs;
    s_start |=> (state == sro_pkg::ST_CONV && serialResultOutputOeN) [*8];
  endproperty
  a_conv_runs: assert property (p_conv_runs) else $error("conversion cut short"); // RULE8
  property p_cs_busy;
    (state == sro_pkg::ST_FINISH && csMode && (!cnvLevel || !sdiLevel))
      |=> (!serialResultOutputOeN && serialResultOutput == sro_pkg::START_BIT);
  endproperty
  a_cs_busy: assert property (p_cs_busy) else $error("busy start bit missing"); // RULE5
  property p_chain_busy;
    (state == sro_pkg::ST_FINISH && !csMode)
      |=> (!serialResultOutputOeN && serialResultOutput == ($past(chainBusy) ? sro_pkg::START_BIT
                                                                             : resultCode[RESULT_BITS-1]));
  endproperty
  a_chain_busy: assert property (p_chain_busy) else $error("chain first bit wrong"); // RULE6
  property p_power_down;
    s_convEnd |-> ##2 (acquiring && state == sro_pkg::ST_ACQ);
  endproperty
  a_power_down: assert property (p_power_down) else $error("no return to acquisition"); // RULE10
  property p_msb_on_select;
    (readStart && state == sro_pkg::ST_ACQ)
      |=> (!serialResultOutputOeN && serialResultOutput == resultCode[RESULT_BITS-1]);
  endproperty
  a_msb_on_select: assert property (p_msb_on_select) else $error("msb not driven on select"); // RULE11
  property p_shift;
    (driving && edgeSeen && !readStart && !convStart && state == sro_pkg::ST_ACQ)
      |=> (serialResultOutput == $past(shiftReg[SW-2]));
  endproperty
  a_shift: assert property (p_shift) else $error("bit not shifted on falling edge"); // RULE12
  property p_stop_count;
    (driving && !chainRun && edgeSeen && bitsLeft == FW'(1) && !readStart && state == sro_pkg::ST_ACQ && !cnvRise)
      |=> serialResultOutputOeN;
  endproperty
  a_stop_count: assert property (p_stop_count) else $error("output not floated after last bit"); // RULE14
  property p_stop_deselect;
    (driving && !chainRun && !selectLevel && selectPrev) |=> serialResultOutputOeN;
  endproperty
  a_stop_deselect: assert property (p_stop_deselect) else $error("output not floated on deselect"); // RULE14
  property p_chain_feed;
    (chainRun && driving && edgeSeen && state == sro_pkg::ST_ACQ && !cnvRise)
      |=> (shiftReg[chainBusy ? 0 : 1] == $past(linkSdi));
  endproperty
  a_chain_feed: assert property (p_chain_feed) else $error("chain input not shifted in"); // RULE16
  property p_clamp_low;
    (s_convEnd and (sampleHeld < 0)) |=> (resultCode == '0);
  endproperty
  a_clamp_low: assert property (p_clamp_low) else $error("underrange not clamped"); // RULE17
  property p_result_hold;
    !convLast |=> $stable(resultCode);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("result changed outside conversion end"); // RULE19
endmodule : sro_sar_adc_readout
`default_nettype wire

/* sro_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sro_host_model #(
  parameter int CONV_CYCLES = 20
) (
  // clock
  input  wire logic clk,
  // pins toward the converter
  output var logic  conversionStartInput,
  output var logic  selectChainInput,
  output var logic  serialClock,
  // pins from the converter
  input  wire logic serialResultOutput,
  input  wire logic serialResultOutputOeN
);
  logic lastDriven;
  logic sdoLine;
  int   edgeSlips;
  initial begin
    conversionStartInput = 1'b0;
    selectChainInput = 1'b1;
    serialClock = 1'b0;
    lastDriven = 1'b0;
    edgeSlips = 0;
  end
  // a released line shows the opposite of its last driven bit
  always @(posedge clk) begin
    if (!serialResultOutputOeN) lastDriven <= serialResultOutput;
  end
  assign sdoLine = serialResultOutputOeN ? ~lastDriven : serialResultOutput;
  // mode 0 chip-select, 1 chain, 2 select tied to start
  task automatic startConv(input int mode, input logic sckHigh);
    @(posedge clk);
    #1;
    conversionStartInput = 1'b0;
    selectChainInput = (mode == 0);
    serialClock = sckHigh;
    repeat (6) @(posedge clk);
    #1;
    conversionStartInput = 1'b1;
    if (mode == 2) selectChainInput = 1'b1;
    repeat (6) @(posedge clk);
    #1;
    selectChainInput = 1'b1;
    serialClock = 1'b0;
  endtask : startConv
  // wait out the longest conversion before reading
  task automatic waitConv();
    repeat (CONV_CYCLES + 12) @(posedge clk);
    #1;
  endtask : waitConv
  task automatic setStart(input logic level);
    @(posedge clk);
    #1;
    conversionStartInput = level;
  endtask : setStart
  // 160 ns clock inside a frame only; capture at rise, recheck before fall
  task automatic shiftIn(input int n, output logic [31:0] bits);
    logic atRise;
    bits = '0;
    #0.3;
    for (int i = 0; i < n; i++) begin
      #80;
      serialClock = 1'b1;
      atRise = sdoLine;
      #79;
      if (sdoLine !== atRise) edgeSlips++;
      bits = {bits[30:0], atRise};
      #1;
      serialClock = 1'b0;
    end
    #40;
  endtask : shiftIn
endmodule : sro_host_model
`default_nettype wire

/* sro_sar_adc_readout_test.sv */
`timescale 1ns/1ps
`default_nettype none
module sro_sar_adc_readout_test;
  localparam int CONV = 20;
  logic               clk;
  logic               srst;
  logic signed [15:0] sampleLevel;
  wire logic          conversion_start_input;
  wire logic          sel;
  wire logic          sck;
  wire logic          serial_result_output;
  wire logic          oeN;
  wire logic          acquiring;
  wire logic [13:0]   resultCode;
  int                 mismatches;
  int                 checks;
  logic [15:0] lv [6] = '{16'h0000, 16'h3fff, 16'h1555, 16'hfffb, 16'h4000, 16'h7fff};
  logic [13:0] ex [6] = '{14'h0000, 14'h3fff, 14'h1555, 14'h0000, 14'h3fff, 14'h3fff};
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  sro_sar_adc_readout #(.CONV_CYCLES(CONV)) DUT (.clk(clk), .srst(srst), .conversionStartInput(conversion_start_input),
    .selectChainInput(sel), .serialClock(sck), .serialResultOutput(serial_result_output), .serialResultOutputOeN(oeN),
    .sampleLevel(sampleLevel), .acquiring(acquiring), .resultCode(resultCode));
  sro_host_model #(.CONV_CYCLES(CONV)) host (.clk(clk), .conversionStartInput(conversion_start_input), .selectChainInput(sel),
    .serialClock(sck), .serialResultOutput(serial_result_output), .serialResultOutputOeN(oeN));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic final_report();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report
  task automatic setLevel(input logic [15:0] level);
    @(posedge clk);
    #1;
    sampleLevel = level;
  endtask : setLevel
  task automatic readCs(input logic [15:0] level, input logic [13:0] exp, input logic bounce);
    logic [31:0] v;
    setLevel(level);
    host.startConv(0, 1'b0);
    setLevel(~level);
    check(oeN, 1);
    check(acquiring, 0);
    if (bounce) begin
      host.setStart(1'b0);
      repeat (3) @(posedge clk);
      host.setStart(1'b1);
    end
    host.waitConv();
    check(acquiring, 1);
    check(resultCode, exp);
    check(oeN, 1);
    host.setStart(1'b0);
    repeat (8) @(posedge clk);
    check(oeN, 0);
    host.shiftIn(14, v);
    check(v, exp);
    check(oeN, 1);
    check(resultCode, exp);
  endtask : readCs
  task automatic abortCs();
    logic [31:0] v;
    setLevel(16'h2000);
    host.startConv(0, 1'b1);
    host.waitConv();
    host.setStart(1'b0);
    repeat (8) @(posedge clk);
    host.shiftIn(5, v);
    check(v, 32'h10);
    host.setStart(1'b1);
    repeat (8) @(posedge clk);
    check(oeN, 1);
    host.waitConv();
    check(acquiring, 1);
  endtask : abortCs
  task automatic busyCs();
    logic [31:0] v;
    setLevel(16'h0abc);
    host.startConv(0, 1'b0);
    host.setStart(1'b0);
    host.waitConv();
    check(oeN, 0);
    host.shiftIn(15, v);
    check(v, {1'b0, 14'h0abc});
    check(oeN, 1);
  endtask : busyCs
  task automatic chainRead(input int mode, input logic sckHi, input logic [13:0] exp);
    logic [31:0] v;
    setLevel({2'b00, exp});
    host.startConv(mode, sckHi);
    host.waitConv();
    check(oeN, 0);
    host.shiftIn(sckHi ? 17 : 16, v);
    check(v, sckHi ? {1'b0, exp, 2'b11} : {exp, 2'b11});
    check(oeN, 0);
  endtask : chainRead
  initial begin
    srst = 1'b1;
    sampleLevel = '0;
    mismatches = 0;
    checks = 0;
    repeat (10) @(posedge clk);
    #1;
    check(oeN, 1);
    check(acquiring, 1);
    check(resultCode, 0);
    srst = 1'b0;
    repeat (5) @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      readCs(lv[i], ex[i], i == 2);
    end
    abortCs();
    busyCs();
    chainRead(1, 1'b0, 14'h2d4b);
    chainRead(2, 1'b0, 14'h1234);
    chainRead(1, 1'b1, 14'h3c01);
    check(host.edgeSlips, 0);
    final_report();
  end
  initial begin
    #200us;
    mismatches++;
    $display("[ERR] t=%0t watchdog got=%h exp=%h", $time, 1'b1, 1'b0);
    final_report();
  end
endmodule : sro_sar_adc_readout_test
`default_nettype wire
